// [design/wdnt_pkg.sv]
// Package for the watchdog/NMI timer: register map, fields, resets, timing.
// Assumes a 10 MHz system clock and a 32.768 kHz low-speed crystal clock.
package wdnt_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] WDNT_CTRL_ADDR = 16'hff07;
    localparam int WDNT_CLEAR_BIT = 0;
    localparam int WDNT_ENABLE_BIT = 1;
    localparam logic WDNT_ENABLE_RST = 1'b1;
    localparam logic [3:0] WDNT_RDATA_IDLE = 4'h0;
    // ------------------------------------------------------------
    // Counter and vector
    // ------------------------------------------------------------
    localparam int WDNT_CNT_W = 10;
    localparam logic [9:0] WDNT_CNT_MAX = 10'h3ff;
    localparam logic [15:0] WDNT_NMI_VECTOR = 16'h0100;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int WDNT_CRYSTAL_HZ = 32768;
    localparam int WDNT_TICK_HZ = 256;
    localparam int WDNT_TICK_DIV = WDNT_CRYSTAL_HZ / WDNT_TICK_HZ;
    localparam int WDNT_DIV_W = 7;
    localparam logic [6:0] WDNT_DIV_LAST = 7'(WDNT_TICK_DIV - 1);
endpackage : wdnt_pkg

// [design/wdnt_tick_gen.sv]
// Divides the low-speed crystal clock down to a 256 Hz one-cycle tick.
// Assumes the crystal clock is far slower than clk and asynchronous to it.
`timescale 1ns/1ps
module wdnt_tick_gen #(
    parameter logic [6:0] DIV_LAST = wdnt_pkg::WDNT_DIV_LAST
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic low_speed_crystal_clock,
    output logic tick_256
);
    // ------------------------------------------------------------
    // Synchroniser and edge detect
    // ------------------------------------------------------------
    logic sync1_r;
    logic sync2_r;
    logic sync3_r;
    logic [6:0] div_r;
    logic [6:0] div_nxt;
    logic tick_r;
    wire xtal_rise = sync2_r & ~sync3_r;
    wire div_wrap = xtal_rise && (div_r == DIV_LAST);

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    // [R1] Crystal derived tick
    assign div_nxt = div_wrap ? 7'h00 : (xtal_rise ? div_r + 7'h01 : div_r);

    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
            div_r <= 7'h00;
            tick_r <= 1'b0;
        end else begin
            sync1_r <= low_speed_crystal_clock;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            div_r <= div_nxt;
            tick_r <= div_wrap;
        end
    end

    assign tick_256 = tick_r;

    // [R1] Tick is single cycle
    AST_TICK_PULSE: assert property (@(posedge clk) disable iff (rst)
        tick_r |=> !tick_r) // [R1]
        else $error("256 Hz tick lasted more than one cycle");
endmodule : wdnt_tick_gen

// [design/wdnt_top.sv]
// Watchdog timer raising a non-maskable interrupt to the core CPU.
// Assumes the CPU I/O bus on clk: one-cycle write and read strobes, 4-bit
// data; stack pointer half-write pulses come from the CPU on clk.
//
// Functional notes
// [R1] Counter advances on crystal derived 256 Hz
// [R2] Enable is 1 after reset
// [R3] 10-bit counter overflow raises the NMI
// [R4] Counts in HALT; NMI releases HALT
// [R5] NMI ignores the global interrupt flag
// [R6] No NMI during interrupt mask state
// [R7] Taken NMI fetches vector 0100H
// [R8] Enable bit D1 starts/stops, suppresses NMI
// [R9] Writing clear 1 restarts counter
// [R10] Clear bit always reads 0
// [R11] Software clears within 3 seconds
// [R12] Unused watchdog disabled soon after reset
// [R13] Upper two bits read 0, ignore writes
`timescale 1ns/1ps
module wdnt_top #(
    // Divider end count; a smaller value shortens the timeout
    parameter logic [6:0] TICK_DIV_LAST = wdnt_pkg::WDNT_DIV_LAST
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic low_speed_crystal_clock,
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [3:0] io_wdata,
    output logic [3:0] io_rdata,
    input wire logic stack_ptr_first_half_wr,
    input wire logic stack_ptr_second_half_wr,
    output logic nmi_pending,
    output logic nmi_take,
    output logic [15:0] nmi_vector,
    output logic halt_wake,
    output logic int_mask_state
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic tick;
    logic enable_r;
    logic [9:0] cnt_r;
    logic [9:0] cnt_nxt;
    logic pend_r;
    logic take_r;
    logic mask_r;
    logic half_r;
    logic [3:0] rdata_r;
    logic [3:0] rdata_nxt;
    logic [15:0] vec_r;

    wdnt_tick_gen #(
        .DIV_LAST(TICK_DIV_LAST)
    ) u_tick (
        .clk(clk),
        .rst(rst),
        .low_speed_crystal_clock(low_speed_crystal_clock),
        .tick_256(tick)
    );

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    wire hit = (io_addr == wdnt_pkg::WDNT_CTRL_ADDR);
    wire wr_hit = hit & io_wr;
    wire rd_hit = hit & io_rd;
    // [R9] Clear on write 1
    wire clr = wr_hit & io_wdata[wdnt_pkg::WDNT_CLEAR_BIT];
    // [R1] Advance on tick
    wire step = tick & enable_r;
    // [R3] Overflow of last stage
    wire ovf = step && (cnt_r == wdnt_pkg::WDNT_CNT_MAX) && !clr;
    // [R5] Global flag not consulted
    wire take_ok = pend_r & ~mask_r & ~take_r;

    // Clear has priority so a restart never races an overflow
    assign cnt_nxt = clr ? '0 : (step ? cnt_r + 10'h001 : cnt_r);
    // [R10] Clear bit reads 0
    // [R13] Upper bits read 0
    assign rdata_nxt = rd_hit ?
        {2'b00, enable_r, 1'b0} : wdnt_pkg::WDNT_RDATA_IDLE;

    // ------------------------------------------------------------
    // Control and counter
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            // [R2] Enable resets to 1
            enable_r <= wdnt_pkg::WDNT_ENABLE_RST;
            cnt_r <= '0;
            rdata_r <= wdnt_pkg::WDNT_RDATA_IDLE;
        end else begin
            // [R8] Enable bit write
            if (wr_hit) begin
                enable_r <= io_wdata[wdnt_pkg::WDNT_ENABLE_BIT];
            end
            cnt_r <= cnt_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // NMI request, mask state and acceptance
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            pend_r <= 1'b0;
            take_r <= 1'b0;
            mask_r <= 1'b1;
            half_r <= 1'b0;
            vec_r <= 16'h0000;
        end else begin
            // [R3] Overflow sets request; set wins over take
            if (ovf) begin
                pend_r <= 1'b1;
            end else if (take_ok) begin
                pend_r <= 1'b0;
            end
            // [R6] Held off while masked
            take_r <= take_ok;
            // [R7] Vector presented
            if (take_ok) begin
                vec_r <= wdnt_pkg::WDNT_NMI_VECTOR;
            end
            // [R6] Mask until pair written
            if (stack_ptr_first_half_wr) begin
                mask_r <= 1'b1;
                half_r <= 1'b1;
            end else if (stack_ptr_second_half_wr && half_r) begin
                mask_r <= 1'b0;
                half_r <= 1'b0;
            end
        end
    end

    // [R4] Pending NMI wakes HALT
    assign halt_wake = pend_r;
    assign nmi_pending = pend_r;
    assign nmi_take = take_r;
    assign nmi_vector = vec_r;
    assign io_rdata = rdata_r;
    assign int_mask_state = mask_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_clear_write;
        wr_hit && io_wdata[wdnt_pkg::WDNT_CLEAR_BIT];
    endsequence

    sequence s_idle_write;
        wr_hit && !io_wdata[wdnt_pkg::WDNT_CLEAR_BIT] && !tick;
    endsequence

    sequence s_last_step;
        tick && enable_r && cnt_r == wdnt_pkg::WDNT_CNT_MAX && !clr;
    endsequence

    // [R2] Enabled out of reset
    AST_ENABLE_AT_RESET: assert property (@(posedge clk) // [R2]
        $fell(rst) |-> enable_r)
        else $error("Watchdog not enabled after reset");

    // [R9] Clear zeroes counter
    AST_CLEAR_RESTART: assert property (@(posedge clk) // [R9]
        disable iff (rst) s_clear_write |=> cnt_r == 10'h000)
        else $error("Clear write did not zero the counter");

    // [R9] Clear of zero ignored
    AST_CLEAR_ZERO_IDLE: assert property (@(posedge clk) // [R9]
        disable iff (rst) s_idle_write |=> $stable(cnt_r))
        else $error("Clear write of zero moved the counter");

    // [R8] Disabled counter holds
    AST_DISABLED_HOLDS: assert property (@(posedge clk) // [R8]
        disable iff (rst) !enable_r && !clr |=> $stable(cnt_r))
        else $error("Counter moved while disabled");

    // [R8] Disabled raises no NMI
    AST_DISABLED_NO_NMI: assert property (@(posedge clk) // [R8]
        disable iff (rst) !enable_r && !pend_r |=> !pend_r)
        else $error("NMI raised while disabled");

    // [R1] Steps only on tick
    AST_TICK_STEP: assert property (@(posedge clk) // [R1]
        disable iff (rst) !tick && !clr |=> $stable(cnt_r))
        else $error("Counter moved without a tick");

    // [R3] One step per tick
    AST_STEP_ONE: assert property (@(posedge clk) // [R3]
        disable iff (rst) step && !clr |=> cnt_r == $past(cnt_r) + 10'h001)
        else $error("Counter did not advance by one");

    // [R3] Overflow raises request
    AST_OVF_PENDS: assert property (@(posedge clk) // [R3]
        disable iff (rst) s_last_step |=> pend_r && halt_wake)
        else $error("Overflow did not raise the NMI");

    // [R10] Fixed zero bits
    AST_READ_ZEROS: assert property (@(posedge clk) // [R10]
        disable iff (rst) rd_hit |=> io_rdata[3:2] == 2'b00 && !io_rdata[0])
        else $error("Clear or upper bits read nonzero");

    // [R6] Mask holds off take
    AST_MASK_BLOCKS: assert property (@(posedge clk) // [R6]
        disable iff (rst) mask_r |=> !take_r)
        else $error("NMI taken in mask state");

    // [R6] First half enters mask
    AST_MASK_ENTRY: assert property (@(posedge clk) // [R6]
        disable iff (rst) stack_ptr_first_half_wr |=> mask_r)
        else $error("Mask state not entered on first half");

    // [R6] Take needs unmasked request
    AST_TAKE_SOURCE: assert property (@(posedge clk) // [R6]
        disable iff (rst) take_r |-> $past(pend_r) && !$past(mask_r))
        else $error("NMI taken without an unmasked request");

    // [R5] Unmasked request taken
    AST_TAKE_UNMASKED: assert property (@(posedge clk) // [R5]
        disable iff (rst) pend_r && !mask_r |-> ##[0:1] take_r)
        else $error("Unmasked NMI not taken");

    // [R7] Take is one cycle
    AST_TAKE_PULSE: assert property (@(posedge clk) // [R7]
        disable iff (rst) take_r |=> !take_r)
        else $error("NMI take lasted more than one cycle");

    // [R7] Vector on take
    AST_VECTOR: assert property (@(posedge clk) // [R7]
        disable iff (rst) take_r |-> nmi_vector == wdnt_pkg::WDNT_NMI_VECTOR)
        else $error("Wrong NMI vector");
endmodule : wdnt_top

// [verification/wdnt_cpu_model.sv]
// Core CPU model: stack pointer loads and NMI acceptance count.
// Assumes wdnt_top outputs on clk; drives its pulses at rising edges.
`timescale 1ns/1ps
module wdnt_cpu_model (
    input wire logic clk,
    input wire logic nmi_take,
    output logic sp_first_wr,
    output logic sp_second_wr
);
    int takes = 0;
    initial begin
        sp_first_wr = 1'b0;
        sp_second_wr = 1'b0;
    end
    // Counts accepted NMIs
    always @(posedge clk) begin
        if (nmi_take === 1'b1) begin
            takes <= takes + 1;
        end
    end
    task automatic load_half(input logic second);
        @(posedge clk);
        sp_first_wr <= !second;
        sp_second_wr <= second;
        @(posedge clk);
        sp_first_wr <= 1'b0;
        sp_second_wr <= 1'b0;
    endtask : load_half
endmodule : wdnt_cpu_model

// [verification/wdnt_top_tb.sv]
// Self-checking bench for wdnt_top with a core CPU model.
// Assumes crystal toggled every 2 clk; divider end 1 gives a tick per 8 clk.
`timescale 1ns/1ps
module wdnt_top_tb;
    localparam int TICK = 8;
    localparam int LIMIT = 40000;
    logic clk = 1'b0, rst = 1'b1, xtal = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
    logic [15:0] io_addr = 16'h0000;
    logic [3:0] io_wdata = 4'h0;
    logic [3:0] io_rdata;
    logic [15:0] nmi_vector;
    logic spf, sps, pend, take, wake, mask;
    int failures = 0, num_checks = 0, cycles = 0, n;
    wdnt_top #(.TICK_DIV_LAST(7'h01)) u_wdnt_top (.clk(clk), .rst(rst),
        .low_speed_crystal_clock(xtal), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .stack_ptr_first_half_wr(spf), .stack_ptr_second_half_wr(sps),
        .nmi_pending(pend), .nmi_take(take), .nmi_vector(nmi_vector),
        .halt_wake(wake), .int_mask_state(mask));
    wdnt_cpu_model u_wdnt_cpu_model (.clk(clk), .nmi_take(take),
        .sp_first_wr(spf), .sp_second_wr(sps));
    // ------------------------------------------------------------
    // Clocks, timeout, shared tasks
    // ------------------------------------------------------------
    initial begin
        forever #50 clk = ~clk;
    end
    initial begin
        forever begin
            repeat (2) @(posedge clk);
            xtal <= ~xtal;
        end
    end
    // Hang guard above the longest expected run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            failures++;
            test_done();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [3:0] d);
        @(posedge clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge clk);
        io_wr <= 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [15:0] a, input logic [3:0] exp);
        @(posedge clk);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge clk);
        io_rd <= 1'b0;
        @(negedge clk);
        chk({12'h000, io_rdata}, {12'h000, exp});
    endtask : rd_chk
    task automatic test_done();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        @(negedge clk);
        chk({15'h0000, mask}, 16'h0001);
        chk(nmi_vector, 16'h0000);
        rd_chk(16'hff07, 4'h2);
        wr(16'hff07, 4'hf);
        rd_chk(16'hff07, 4'h2);
        rd_chk(16'hff07, 4'h2);
        rd_chk(16'hff06, 4'h0);
        wr(16'hff07, 4'h0);
        rd_chk(16'hff07, 4'h0);
    endtask : t_regs
    task automatic t_mask_order();
        u_wdnt_cpu_model.load_half(1'b0);
        @(negedge clk);
        chk({15'h0000, mask}, 16'h0001);
        u_wdnt_cpu_model.load_half(1'b1);
        @(negedge clk);
        chk({15'h0000, mask}, 16'h0000);
        u_wdnt_cpu_model.load_half(1'b0);
        @(negedge clk);
        chk({15'h0000, mask}, 16'h0001);
    endtask : t_mask_order
    // Disabled gap is longer than a timeout; clear restarts from zero
    task automatic t_overflow();
        repeat (9000) @(posedge clk);
        chk({15'h0000, pend}, 16'h0000);
        wr(16'hff07, 4'h2);
        repeat (2000) @(posedge clk);
        wr(16'hff07, 4'h3);
        n = 0;
        while (pend !== 1'b1 && n < LIMIT) begin
            @(posedge clk);
            n++;
        end
        chk({15'h0000, n > 1023 * TICK}, 16'h0001);
        chk({15'h0000, n <= 1024 * TICK + 8}, 16'h0001);
        repeat (20) @(posedge clk);
        #1;
        chk(16'(u_wdnt_cpu_model.takes), 16'h0000);
        chk({15'h0000, wake}, 16'h0001);
        u_wdnt_cpu_model.load_half(1'b1);
        repeat (4) @(posedge clk);
        #1;
        chk(16'(u_wdnt_cpu_model.takes), 16'h0001);
        chk(nmi_vector, 16'h0100);
        chk({14'h0000, pend, wake}, 16'h0000);
    endtask : t_overflow
    // Mid-count write with clear 0 must not restart the count
    task automatic t_clear_zero();
        wr(16'hff07, 4'h3);
        repeat (4000) @(posedge clk);
        wr(16'hff07, 4'h2);
        n = 4002;
        while (pend !== 1'b1 && n < LIMIT) begin
            @(posedge clk);
            n++;
        end
        chk({15'h0000, n > 1023 * TICK}, 16'h0001);
        chk({15'h0000, n <= 1024 * TICK + 8}, 16'h0001);
        repeat (4) @(posedge clk);
        #1;
        chk(16'(u_wdnt_cpu_model.takes), 16'h0002);
    endtask : t_clear_zero
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_mask_order();
        t_overflow();
        t_clear_zero();
        test_done();
    end
endmodule : wdnt_top_tb
